// ==== dv/irq_core_model.sv ====
`timescale 1ns/100ps
module irq_core_model (
	input  wire logic                 clock,   // System clock
	output logic [31:0]               src_req, // Source pulses
	output irq_flag_pkg::irq_ack_type ack      // Core acknowledge
);
	initial begin
		src_req = '0;
		ack = '0;
	end
	task automatic fire(logic [31:0] v);
		@(negedge clock);
		src_req = v;
		@(negedge clock);
		src_req = '0;
	endtask
	task automatic take(logic [4:0] s);
		@(negedge clock);
		ack = {1'b1, s};
		@(negedge clock);
		ack = '0;
	endtask
endmodule

// ==== dv/irq_flag_bank_assertions.sv ====
`timescale 1ns/100ps
module irq_flag_bank_assertions (
	input wire logic                      clock,   // System clock
	input wire logic                      rstn,    // Reset, low
	input wire logic [31:0]               src_req, // Source requests
	input wire irq_flag_pkg::irq_ack_type ack,     // Acknowledge
	input wire irq_flag_pkg::reg_req_type req,     // Register access
	input wire logic [15:0]               rdata,   // Read data
	input wire logic [31:0]               flags    // Pending flags
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	wire quiet = (src_req == '0) && !ack.valid;
	wire wr_a = req.valid && req.write && req.addr == irq_flag_pkg::ADDR_BYTE_A;
	sequence rd_byte_a;
		req.valid && !req.write && req.size == irq_flag_pkg::ACC_BYTE
			&& req.addr == irq_flag_pkg::ADDR_BYTE_A;
	endsequence
	a_unused_zero: assert property (
		(flags & ~irq_flag_pkg::FLAG_MASK) == '0) else $error("unused bit set");
	a_src_sets: assert property (
		(src_req & irq_flag_pkg::FLAG_MASK) != '0 |=> (flags & $past(src_req)
		& irq_flag_pkg::FLAG_MASK) == ($past(src_req) & irq_flag_pkg::FLAG_MASK))
		else $error("request not latched");
	a_ack_clears: assert property (
		ack.valid && !req.valid && !src_req[ack.source]
		|=> !flags[$past(ack.source)]) else $error("ack did not clear");
	a_read_next: assert property (
		rd_byte_a |=> rdata == {8'h00, $past(flags[7:0])}) else $error("bad read");
	a_rdata_idle: assert property (
		!(req.valid && !req.write) |=> rdata == '0) else $error("rdata not zero");
	a_bit_clear: assert property (
		wr_a && req.size == irq_flag_pkg::ACC_BIT && !req.wdata[0] && quiet
		|=> flags[7:0] == ($past(flags[7:0]) & ~(8'h01 << $past(req.bit_sel))))
		else $error("bit clear touched others");
	a_flags_hold: assert property (
		!req.valid && quiet |=> $stable(flags)) else $error("flags changed");
	a_word_write: assert property (
		wr_a && req.size == irq_flag_pkg::ACC_WORD && quiet
		|=> flags[15:0] == $past(req.wdata)) else $error("word write wrong");
endmodule

// ==== dv/irq_flag_bank_tb.sv ====
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error %0t: got %h expected %h", $time, a, e); end end
module irq_flag_bank_tb;
	logic                      clock = 0;
	logic                      rstn = 0;
	logic [31:0]               src_req;
	irq_flag_pkg::irq_ack_type ack;
	irq_flag_pkg::reg_req_type req = '0;
	logic [15:0]               rdata;
	logic [31:0]               flags;
	int                        n_mismatch = 0;
	int                        cmp_count = 0;
	irq_flag_bank u_dut (.clock(clock), .rstn(rstn), .src_req(src_req),
		.ack(ack), .req(req), .rdata(rdata), .flags(flags));
	irq_core_model u_core (.clock(clock), .src_req(src_req), .ack(ack));
	initial forever #20 clock = ~clock;
	task automatic acc(logic w, logic [1:0] s, logic [15:0] a, logic [2:0] b,
		logic [15:0] d);
		@(negedge clock);
		req = {1'b1, w, irq_flag_pkg::access_size_type'(s), a, b, d};
		@(negedge clock);
		req = '0;
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		wrap_up;
	end
	initial begin
		repeat (5) @(negedge clock);
		rstn = 1;
		repeat (3) @(negedge clock);
		for (int i = 0; i < 4; i++) begin
			acc(0, 1, 16'hFFE0 + 16'(i), 0, 0);
			`CHK(rdata, 16'h0000)
		end
		$display("reset values done");
		acc(1, 2, 16'hFFE0, 0, 16'h00FF);
		acc(0, 2, 16'hFFE0, 0, 0);
		`CHK(rdata, 16'h00FF)
		acc(1, 0, 16'hFFE0, 3, 0);
		`CHK(flags[7:0], 8'hF7)
		acc(0, 0, 16'hFFE0, 2, 0);
		`CHK(rdata, 16'h0001)
		acc(0, 0, 16'hFFE0, 3, 0);
		`CHK(rdata, 16'h0000)
		acc(1, 1, 16'hFFE1, 0, 16'h00A5);
		`CHK(flags[15:0], 16'hA5F7)
		acc(1, 2, 16'hFFE2, 0, 16'h0009);
		acc(0, 2, 16'hFFE2, 0, 0);
		`CHK(rdata, 16'h0009)
		acc(0, 1, 16'h1234, 0, 0);
		`CHK(rdata, 16'h0000)
		$display("register access done");
		u_core.fire(32'hFFFFFFFF);
		`CHK(flags, irq_flag_pkg::FLAG_MASK)
		acc(0, 2, 16'hFFE3, 0, 0);
		`CHK(rdata, 16'h0009)
		u_core.take(5'h10);
		`CHK(flags[16], 1'b0)
		acc(1, 0, 16'hFFE1, 5, 0);
		`CHK(flags[13], 1'b0)
		fork
			u_core.fire(32'h8);
			acc(1, 0, 16'hFFE0, 3, 0);
		join
		`CHK(flags[3], 1'b1)
		$display("source requests done");
		@(negedge clock);
		rstn = 0;
		repeat (2) @(negedge clock);
		rstn = 1;
		repeat (3) @(negedge clock);
		`CHK(flags, 32'h00000000)
		acc(0, 2, 16'hFFE0, 0, 0);
		`CHK(rdata, 16'h0000)
		$display("mid-run reset done");
		wrap_up;
	end
endmodule
bind irq_flag_bank irq_flag_bank_assertions u_chk (.clock(clock), .rstn(rstn),
	.src_req(src_req), .ack(ack), .req(req), .rdata(rdata), .flags(flags));

// ==== hdl/irq_flag_bank.sv ====
`timescale 1ns/100ps
// Overview of operation
// - A flag sets on its source request or a software write of one.
// - Core acknowledge clears the acknowledged source flag before service.
// - Reset clears all four flag bytes to zero.
// - Bit, byte and paired 16-bit word accesses are all supported.
// - Flag zero means nothing pending; one means request pending.
// - Byte a holds low voltage, pins 0-3, USB 0, USB 1, UART error.
// - Byte b holds UART rx/tx, serial, timer H, USB 2, timers 50/00.
// - Byte c holds USB resume at bit 0, timer 51 at bit 3.
// - Byte d has no flags and reads as zero.
// - A single-bit clear changes only the addressed bit.
// - Each source has request, mask and priority flags at one position.
// - Six register groups govern interrupts; this bank is the first.
// - Mask zero allows servicing, mask one blocks it.
// - Priority zero is high level, priority one is low level.
// - Equal-level requests are served lowest source number first.
module irq_flag_bank (
	input  wire logic                      clock,     // 25 MHz system clock
	input  wire logic                      rstn,      // Async reset, low
	input  wire logic [31:0]               src_req,   // Source request pulses
	input  wire irq_flag_pkg::irq_ack_type ack,       // Core acknowledge
	input  wire irq_flag_pkg::reg_req_type req,       // Register access
	output logic [15:0]                    rdata,     // Read data, next cycle
	output logic [31:0]                    flags      // Pending flags
);
	logic        rstn_meta_reg;
	logic        rstn_sync_reg;
	logic        bank_hit;
	logic [31:0] flag_state;
	logic [31:0] flags_next;
	logic [31:0] wr_set;
	logic [31:0] wr_clr;
	logic [31:0] ack_clr;
	logic [31:0] set_bits;
	logic [31:0] clr_bits;
	logic [31:0] sel;
	logic [31:0] wdata32;
	logic [1:0]  word_idx;
	logic [4:0]  bit_idx;
	logic [7:0]  request_flags_byte_a;
	logic [7:0]  request_flags_byte_b;
	logic [7:0]  request_flags_byte_c;
	logic [7:0]  request_flags_byte_d;
	logic [7:0]  byte_a_next;
	logic [7:0]  byte_b_next;
	logic [7:0]  byte_c_next;

	// Assertion is immediate, release waits two clock edges
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstn_meta_reg <= 1'b0;
			rstn_sync_reg <= 1'b0;
		end else begin
			rstn_meta_reg <= 1'b1;
			rstn_sync_reg <= rstn_meta_reg;
		end
	end

	assign bank_hit = req.valid &&
		req.addr[15:2] == irq_flag_pkg::ADDR_BYTE_A[15:2];

	// Decode which flag bits the access touches and what it writes
	always_comb begin
		sel      = 32'h0;
		wdata32  = 32'h0;
		word_idx = req.addr[1:0];
		bit_idx  = {word_idx, req.bit_sel};
		case (req.size)
			irq_flag_pkg::ACC_BIT: begin
				sel[bit_idx]     = 1'b1;
				wdata32[bit_idx] = req.wdata[0];
			end
			irq_flag_pkg::ACC_BYTE: begin
				sel     = 32'h000000FF << {word_idx, 3'b000};
				wdata32 = {24'h0, req.wdata[7:0]} << {word_idx, 3'b000};
			end
			irq_flag_pkg::ACC_WORD: begin
				// Word access uses the even byte of each pair
				sel     = 32'h0000FFFF << {word_idx[1], 4'b0000};
				wdata32 = {16'h0, req.wdata} << {word_idx[1], 4'b0000};
			end
			default: begin
				sel     = 32'h0;
				wdata32 = 32'h0;
			end
		endcase
		if (!(bank_hit && req.write)) begin
			sel = 32'h0;
		end
		wr_set = sel & wdata32;
		wr_clr = sel & ~wdata32;
	end

	always_comb begin
		ack_clr = 32'h0;
		if (ack.valid) begin
			ack_clr[ack.source] = 1'b1;
		end
	end

	// Hardware requests only reach implemented positions
	always_comb begin
		set_bits = wr_set | (src_req & irq_flag_pkg::FLAG_MASK);
		clr_bits = wr_clr | ack_clr;
	end

	flag_byte_cell #(
		.IMPL_MASK   (irq_flag_pkg::FLAG_MASK[7:0]),
		.RESET_VALUE (irq_flag_pkg::FLAG_RESET)
	) u_byte_a (
		.clock     (clock),
		.rstn_sync (rstn_sync_reg),
		.set_bits  (set_bits[7:0]),
		.clr_bits  (clr_bits[7:0]),
		.next_bits (byte_a_next),
		.flag_bits (request_flags_byte_a)
	);

	flag_byte_cell #(
		.IMPL_MASK   (irq_flag_pkg::FLAG_MASK[15:8]),
		.RESET_VALUE (irq_flag_pkg::FLAG_RESET)
	) u_byte_b (
		.clock     (clock),
		.rstn_sync (rstn_sync_reg),
		.set_bits  (set_bits[15:8]),
		.clr_bits  (clr_bits[15:8]),
		.next_bits (byte_b_next),
		.flag_bits (request_flags_byte_b)
	);

	flag_byte_cell #(
		.IMPL_MASK   (irq_flag_pkg::BYTE_C_MASK),
		.RESET_VALUE (irq_flag_pkg::FLAG_RESET)
	) u_byte_c (
		.clock     (clock),
		.rstn_sync (rstn_sync_reg),
		.set_bits  (set_bits[23:16]),
		.clr_bits  (clr_bits[23:16]),
		.next_bits (byte_c_next),
		.flag_bits (request_flags_byte_c)
	);

	assign request_flags_byte_d = irq_flag_pkg::FLAG_RESET;

	// bit order is default priority
	// Masking and arbitration sit outside and index this vector
	assign flag_state = {request_flags_byte_d, request_flags_byte_c,
		request_flags_byte_b, request_flags_byte_a};
	assign flags_next = {irq_flag_pkg::FLAG_RESET, byte_c_next,
		byte_b_next, byte_a_next};

	always_ff @(posedge clock or negedge rstn_sync_reg) begin
		if (!rstn_sync_reg) begin
			rdata <= 16'h0000;
		end else if (bank_hit && !req.write) begin
			case (req.size)
				irq_flag_pkg::ACC_BIT:
					rdata <= {15'h0000, flag_state[bit_idx]};
				irq_flag_pkg::ACC_BYTE:
					rdata <= {8'h00, flag_state[{word_idx, 3'b000} +: 8]};
				irq_flag_pkg::ACC_WORD:
					rdata <= flag_state[{word_idx[1], 4'b0000} +: 16];
				default:
					rdata <= 16'h0000;
			endcase
		end else begin
			rdata <= 16'h0000;
		end
	end

	// Output copy in its own flop, always equal to the bank
	always_ff @(posedge clock or negedge rstn_sync_reg) begin
		if (!rstn_sync_reg) begin
			flags <= 32'h0;
		end else begin
			flags <= flags_next;
		end
	end
endmodule

// One byte of request flags; unimplemented positions read zero
module flag_byte_cell #(
	parameter logic [7:0] IMPL_MASK   = 8'hFF, // Implemented positions
	parameter logic [7:0] RESET_VALUE = 8'h00  // Value after reset
) (
	input  wire logic       clock,     // System clock
	input  wire logic       rstn_sync, // Synchronised reset, low
	input  wire logic [7:0] set_bits,  // Bits to set
	input  wire logic [7:0] clr_bits,  // Bits to clear
	output logic [7:0]      next_bits, // Value taken at next edge
	output logic [7:0]      flag_bits  // Current flags
);
	logic [7:0] flag_reg;
	logic [7:0] flag_next;

	// hardware or software set
	// Same-cycle set beats clear, so a byte rewrite cannot lose one
	always_comb begin
		flag_next = ((flag_reg & ~clr_bits) | set_bits) & IMPL_MASK;
	end

	always_ff @(posedge clock or negedge rstn_sync) begin
		if (!rstn_sync) begin
			flag_reg <= RESET_VALUE;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign next_bits = flag_next;
	assign flag_bits = flag_reg;
endmodule

// ==== include/irq_flag_pkg.sv ====
package irq_flag_pkg;
	// Byte addresses of the four request flag bytes
	localparam logic [15:0] ADDR_BYTE_A = 16'hFFE0;
	localparam logic [15:0] ADDR_BYTE_B = 16'hFFE1;
	localparam logic [15:0] ADDR_BYTE_C = 16'hFFE2;
	localparam logic [15:0] ADDR_BYTE_D = 16'hFFE3;
	localparam logic [7:0]  FLAG_RESET  = 8'h00;
	// Implemented bit positions of byte c
	localparam logic [7:0]  BYTE_C_MASK = 8'h09;
	localparam int          NUM_SRC     = 19;
	// Source numbers (bit index in the packed 32-bit flag vector)
	localparam int SRC_LOW_VOLTAGE  = 0;
	localparam int SRC_USB_RESUME   = 16;
	localparam int SRC_TIMER_51     = 19;
	// Implemented flag bits across the 32-bit vector
	localparam logic [31:0] FLAG_MASK = 32'h0009FFFF;

	// Access sizes of a memory manipulation
	typedef enum logic [1:0] {
		ACC_BIT,
		ACC_BYTE,
		ACC_WORD
	} access_size_type;

	// Register access request from the core
	typedef struct packed {
		logic            valid;
		logic            write;
		access_size_type size;
		logic [15:0]     addr;
		logic [2:0]      bit_sel;
		logic [15:0]     wdata;
	} reg_req_type;

	// Acknowledge from the core
	typedef struct packed {
		logic       valid;
		logic [4:0] source;
	} irq_ack_type;
endpackage
